// [ibl_defs.vh]
// Purpose: constants for the serial memory boot loader
// Assumes: 25 MHz system clock
// Notes: definitions only
`ifndef IBL_DEFS_VH
`define IBL_DEFS_VH
`define IBL_SLAVE_ADDR 7'h50
`define IBL_KEY_WORD 16'h08aa
`define IBL_START_PTR_HI 8'h00
`define IBL_START_PTR_LO 8'h00
`define IBL_SYS_CLK_HZ 25000000
`define IBL_BIT_RATE_HZ 100000
// half bit period in system clocks: 25e6 / (2 * 100e3)
`define IBL_HALF_BIT ((`IBL_SYS_CLK_HZ / (2 * `IBL_BIT_RATE_HZ)))
`define IBL_RSVD_WORDS 4'h5
`define IBL_DATA_PIN_SEL 6'h20
`define IBL_CLOCK_PIN_SEL 6'h21
`endif

// [ibl_bit_engine.v]
// Purpose: byte level serial bus master engine (start, stop, byte write, byte read)
// Assumes: open-drain bus, single master
// Notes: clock stretching honoured through sampled clock line
`timescale 1ns/1ns
module ibl_bit_engine
(
  input wire clk,
  input wire rst_b,
  input wire [15:0] half_period,
  input wire [7:0] prescale,
  input wire [2:0] cmd,
  input wire cmd_valid,
  input wire [7:0] wr_byte,
  input wire rd_ack,
  input wire sda_in,
  input wire scl_in,
  output reg busy,
  output reg done,
  output reg [7:0] rd_byte,
  output reg nack,
  output reg sda_oe,
  output reg scl_oe
);
// cmd codes: 1 start, 2 stop, 3 write, 4 read
reg [15:0] cnt;
reg [7:0] pcnt;
reg [3:0] bitn;
reg [1:0] ph;
reg [2:0] op;
reg [8:0] sh;
wire tick;
assign tick = (pcnt == 8'h00) && (cnt == 16'h0000);
always @(posedge clk)
begin
  if (!rst_b)
  begin
    busy <= 1'b0;
    done <= 1'b0;
    rd_byte <= 8'h00;
    nack <= 1'b0;
    sda_oe <= 1'b0;
    scl_oe <= 1'b0;
    cnt <= 16'h0000;
    pcnt <= 8'h00;
    bitn <= 4'h0;
    ph <= 2'b00;
    op <= 3'b000;
    sh <= 9'h000;
  end
  else
  begin
    done <= 1'b0;
    if (!busy)
    begin
      if (cmd_valid)
      begin
        busy <= 1'b1;
        op <= cmd;
        ph <= 2'b00;
        bitn <= 4'h0;
        cnt <= half_period;
        pcnt <= prescale;
        sh <= (cmd == 3'h4) ? {8'hff, ~rd_ack} : {wr_byte, 1'b1};
      end
    end
    else if (!scl_oe && !scl_in)
    begin
      // released clock still low (stretch or sampler lag): hold the timer
      cnt <= cnt;
    end
    else if (!tick)
    begin
      if (pcnt != 8'h00)
        pcnt <= pcnt - 8'h01;
      else
      begin
        pcnt <= prescale;
        cnt <= cnt - 16'h0001;
      end
    end
    else
    begin
      cnt <= half_period;
      pcnt <= prescale;
      ph <= ph + 2'b01;
      case (op)
        3'h1:
        begin
          case (ph)
            // data released before clock, so a repeated start is no stop
            2'b00: sda_oe <= 1'b0;
            2'b01: scl_oe <= 1'b0;
            2'b10: sda_oe <= 1'b1;
            default: begin scl_oe <= 1'b1; busy <= 1'b0; done <= 1'b1; end
          endcase
        end
        3'h2:
        begin
          case (ph)
            2'b00: begin scl_oe <= 1'b1; sda_oe <= 1'b1; end
            2'b01: scl_oe <= 1'b0;
            2'b10: sda_oe <= 1'b0;
            default: begin busy <= 1'b0; done <= 1'b1; end
          endcase
        end
        default:
        begin
          // low half drives data; sample at end of high half, after any stretch
          if (ph[0] == 1'b0)
          begin
            scl_oe <= 1'b1;
            if (bitn != 4'h0)
              sh <= {sh[7:0], sda_in};
            if (bitn == 4'h9)
            begin
              busy <= 1'b0;
              done <= 1'b1;
              rd_byte <= sh[7:0];
              nack <= sda_in;
            end
            else if (bitn == 4'h0)
              sda_oe <= ~sh[8];
            else
              sda_oe <= ~sh[7];
          end
          else
          begin
            scl_oe <= 1'b0;
            bitn <= bitn + 4'h1;
            ph <= 2'b00;
          end
        end
      endcase
    end
  end
end
endmodule // ibl_bit_engine

// [ibl_loader.v]
// Purpose: boot loader pulling a program image from a serial memory on a two-wire bus
// Assumes: memory answers at 0x50 with 16-bit word addressing, 8-bit data
// Notes: loaded words leave through a one-cycle write strobe
`timescale 1ns/1ns
`include "ibl_defs.vh"
////////////////////////////////////////////////////////////////////////////////
// Operation
// - address memory at seven-bit address 0x50
// - set pointer with two-byte word address
// - route pins 32 and 33, init first
// - initial timing 50 percent, 100 kHz
// - load prescaler and half periods from stream
// - ignore arbitration, busy, slave-addressed indications
// - check acknowledge only on first transaction
// - later address phases ignore missing acknowledge
// - first transaction random read of key
// - later fetches two-byte sequential reads, low first
// - key arrives as 0xaa then 0x08
// - bytes 19 to 22 entry point, upper first
// - copy size, destination, data until zero size
module ibl_loader
#(
  parameter HALF_BIT = `IBL_HALF_BIT
)
(
  input wire clk,
  input wire rst_b,
  input wire start,
  input wire sda_in,
  input wire scl_in,
  output reg sda_out,
  output reg sda_oe,
  output reg scl_out,
  output reg scl_oe,
  output reg [5:0] boot_serial_data_pin,
  output reg [5:0] boot_serial_clock_pin,
  output reg [7:0] bus_clock_prescaler,
  output reg [15:0] bit_high_period,
  output reg [15:0] bit_low_period,
  output reg [31:0] entry_point,
  output reg [31:0] wr_addr,
  output reg [15:0] wr_data,
  output reg wr_strobe,
  output reg load_done,
  output reg load_fail
);
localparam S_IDLE = 10'h001;
localparam S_PTR = 10'h002;
localparam S_KEY = 10'h004;
localparam S_DIV = 10'h008;
localparam S_RSV = 10'h010;
localparam S_ENT = 10'h020;
localparam S_SIZE = 10'h040;
localparam S_DST = 10'h080;
localparam S_DATA = 10'h100;
localparam S_END = 10'h200;
reg [9:0] state;
reg [3:0] step;
reg [3:0] wcnt;
reg [1:0] ecnt;
reg [15:0] size_left;
reg [15:0] word;
reg [15:0] got;
reg got_v;
reg quit;
reg sda_lag;
reg [2:0] cmd;
reg cmd_valid;
reg [7:0] wr_byte;
reg rd_ack;
reg sda_m;
reg sda_s;
reg scl_m;
reg scl_s;
wire eng_busy;
wire eng_done;
wire [7:0] eng_byte;
wire eng_nack;
wire eng_sda_oe;
wire eng_scl_oe;
wire [15:0] half_period;
////////////////////////////////////////////////////////////////////////////////
// pin sampling and engine
always @(posedge clk)
begin
  if (!rst_b)
  begin
    sda_m <= 1'b1;
    sda_s <= 1'b1;
    scl_m <= 1'b1;
    scl_s <= 1'b1;
  end
  else
  begin
    sda_m <= sda_in;
    sda_s <= sda_m;
    scl_m <= scl_in;
    scl_s <= scl_m;
  end
end
// single half period used for both halves: the high setting, low setting unused
assign half_period = bit_high_period;
ibl_bit_engine u_eng
(
  .clk(clk),
  .rst_b(rst_b),
  .half_period(half_period),
  .prescale(bus_clock_prescaler),
  .cmd(cmd),
  .cmd_valid(cmd_valid),
  .wr_byte(wr_byte),
  .rd_ack(rd_ack),
  .sda_in(sda_s),
  .scl_in(scl_s),
  .busy(eng_busy),
  .done(eng_done),
  .rd_byte(eng_byte),
  .nack(eng_nack),
  .sda_oe(eng_sda_oe),
  .scl_oe(eng_scl_oe)
);
always @(posedge clk)
begin
  if (!rst_b)
  begin
    sda_out <= 1'b0;
    scl_out <= 1'b0;
    sda_lag <= 1'b0;
    sda_oe <= 1'b0;
    scl_oe <= 1'b0;
  end
  else
  begin
    // data moves a cycle after the clock so the two never change together
    sda_lag <= eng_sda_oe;
    sda_oe <= sda_lag;
    scl_oe <= eng_scl_oe;
  end
end
////////////////////////////////////////////////////////////////////////////////
// transaction sequencer: step walks one transaction
// pointer write: start, addr+w, ptr hi, ptr lo; word read: start, addr+r, rd, rd, stop
function [2:0] step_cmd;
  input [3:0] s;
  input first;
  begin
    case (s)
      4'h0: step_cmd = 3'h1;
      4'h1: step_cmd = 3'h3;
      4'h2: step_cmd = first ? 3'h3 : 3'h4;
      4'h3: step_cmd = first ? 3'h3 : 3'h4;
      4'h4: step_cmd = first ? 3'h1 : 3'h2;
      4'h5: step_cmd = 3'h3;
      4'h6: step_cmd = 3'h4;
      4'h7: step_cmd = 3'h4;
      default: step_cmd = 3'h2;
    endcase
  end
endfunction
wire first_tr;
wire [3:0] last_step;
assign first_tr = (state == S_PTR);
assign last_step = first_tr ? 4'h8 : 4'h4;
always @(posedge clk)
begin
  if (!rst_b)
  begin
    state <= S_IDLE;
    step <= 4'h0;
    wcnt <= 4'h0;
    ecnt <= 2'b00;
    size_left <= 16'h0000;
    word <= 16'h0000;
    got <= 16'h0000;
    got_v <= 1'b0;
    quit <= 1'b0;
    cmd <= 3'h0;
    cmd_valid <= 1'b0;
    wr_byte <= 8'h00;
    rd_ack <= 1'b0;
    boot_serial_data_pin <= 6'h00;
    boot_serial_clock_pin <= 6'h00;
    bus_clock_prescaler <= 8'h00;
    bit_high_period <= 16'h0000;
    bit_low_period <= 16'h0000;
    entry_point <= 32'h00000000;
    wr_addr <= 32'h00000000;
    wr_data <= 16'h0000;
    wr_strobe <= 1'b0;
    load_done <= 1'b0;
    load_fail <= 1'b0;
  end
  else
  begin
    cmd_valid <= 1'b0;
    wr_strobe <= 1'b0;
    got_v <= 1'b0;
    // arbitration, busy and slave-addressed status never looked at
    if (state != S_IDLE && state != S_END && !eng_busy && !cmd_valid && !eng_done && !got_v)
    begin
      cmd <= step_cmd(step, first_tr);
      cmd_valid <= 1'b1;
      rd_ack <= (step == (first_tr ? 4'h6 : 4'h2));
      case (step)
        4'h1: wr_byte <= {`IBL_SLAVE_ADDR, ~first_tr};
        4'h2: wr_byte <= `IBL_START_PTR_HI;
        4'h3: wr_byte <= `IBL_START_PTR_LO;
        default: wr_byte <= {`IBL_SLAVE_ADDR, 1'b1};
      endcase
    end
    if (eng_done)
    begin
      if (first_tr && eng_nack && (step == 4'h1 || step == 4'h2 || step == 4'h3))
      begin
        // finish with a stop so the bus is left free for others
        step <= last_step;
        quit <= 1'b1;
      end
      else
      begin
        // later address phase nack ignored; a dead bus then hangs here
        if (step == (first_tr ? 4'h6 : 4'h2))
          word[7:0] <= eng_byte;
        if (step == (first_tr ? 4'h7 : 4'h3))
          word[15:8] <= eng_byte;
        if (step == last_step)
        begin
          step <= 4'h0;
          got <= word;
          got_v <= 1'b1;
        end
        else
          step <= step + 4'h1;
      end
    end
    case (state)
      S_IDLE:
      begin
        if (start)
        begin
          boot_serial_data_pin <= `IBL_DATA_PIN_SEL;
          boot_serial_clock_pin <= `IBL_CLOCK_PIN_SEL;
          bus_clock_prescaler <= 8'h00;
          bit_high_period <= HALF_BIT[15:0];
          bit_low_period <= HALF_BIT[15:0];
          state <= S_PTR;
        end
      end
      S_PTR:
      begin
        if (got_v)
        begin
          if (quit)
          begin
            state <= S_END;
            load_fail <= 1'b1;
          end
          else if (got == `IBL_KEY_WORD)
            state <= S_DIV;
          else
          begin
            state <= S_END;
            load_fail <= 1'b1;
          end
          wcnt <= 4'h0;
        end
      end
      S_DIV:
      begin
        if (got_v)
        begin
          wcnt <= wcnt + 4'h1;
          case (wcnt)
            4'h0: bus_clock_prescaler <= got[7:0];
            4'h1: bit_high_period <= got;
            default:
            begin
              bit_low_period <= got;
              state <= S_RSV;
              wcnt <= 4'h0;
            end
          endcase
        end
      end
      S_RSV:
      begin
        if (got_v)
        begin
          wcnt <= wcnt + 4'h1;
          if (wcnt == `IBL_RSVD_WORDS - 4'h1)
          begin
            state <= S_ENT;
            ecnt <= 2'b00;
          end
        end
      end
      S_ENT:
      begin
        if (got_v)
        begin
          ecnt <= ecnt + 2'b01;
          if (ecnt == 2'b00)
            entry_point[31:16] <= {8'h00, got[7:0]};
          else
          begin
            entry_point[15:0] <= got;
            state <= S_SIZE;
          end
        end
      end
      S_SIZE:
      begin
        if (got_v)
        begin
          if (got == 16'h0000)
          begin
            state <= S_END;
            load_done <= 1'b1;
          end
          else
          begin
            size_left <= got;
            ecnt <= 2'b00;
            state <= S_DST;
          end
        end
      end
      S_DST:
      begin
        if (got_v)
        begin
          ecnt <= ecnt + 2'b01;
          if (ecnt == 2'b00)
            wr_addr[31:16] <= got;
          else
          begin
            wr_addr[15:0] <= got;
            state <= S_DATA;
          end
        end
      end
      S_DATA:
      begin
        if (got_v)
        begin
          wr_data <= got;
          wr_strobe <= 1'b1;
          size_left <= size_left - 16'h0001;
          if (size_left == 16'h0001)
            state <= S_SIZE;
        end
        if (wr_strobe)
          wr_addr <= wr_addr + 32'h00000001;
      end
      S_END:
      begin
        state <= S_END;
      end
      default:
      begin
        state <= S_IDLE;
      end
    endcase
  end
end
endmodule // ibl_loader

// [ibl_loader_assertions.sv]
// Purpose: port checks for the serial memory boot loader
// Assumes: one clock, sync active-low reset
// Notes: bound to every loader
`timescale 1ns/1ns
module ibl_loader_assertions
#(
  parameter HALF_BIT = 125
)
(
  input wire clk,
  input wire rst_b,
  input wire sda_oe,
  input wire scl_oe,
  input wire [5:0] boot_serial_data_pin,
  input wire [5:0] boot_serial_clock_pin,
  input wire [15:0] bit_high_period,
  input wire [15:0] bit_low_period,
  input wire [31:0] entry_point,
  input wire wr_strobe,
  input wire load_done,
  input wire load_fail
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  //////////////////////////////
  property p_pin_route;
    sda_oe || scl_oe |-> boot_serial_data_pin == 6'h20 && boot_serial_clock_pin == 6'h21;
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("bus driven unrouted");
  property p_init_rate;
    $rose(boot_serial_data_pin[5]) |-> ##[0:3]
      (bit_high_period == HALF_BIT && bit_low_period == HALF_BIT);
  endproperty
  a_init_rate: assert property (p_init_rate) else $error("initial rate wrong");
  property p_entry_top;
    entry_point[31:24] == 8'h00;
  endproperty
  a_entry_top: assert property (p_entry_top) else $error("entry top byte set");
  property p_end_sticky;
    load_done |=> load_done && !load_fail;
  endproperty
  a_end_sticky: assert property (p_end_sticky) else $error("done not held");
  property p_fail_sticky;
    load_fail |=> load_fail && !load_done;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("fail not held");
  property p_no_late_write;
    load_fail || load_done |-> !wr_strobe;
  endproperty
  a_no_late_write: assert property (p_no_late_write) else $error("write after end");
  property p_strobe_pulse;
    wr_strobe |=> !wr_strobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
  // a stuck line would block any later master
  property p_release;
    $rose(load_done || load_fail) |-> ##[0:600] (!sda_oe && !scl_oe);
  endproperty
  a_release: assert property (p_release) else $error("bus kept after end");
endmodule // ibl_loader_assertions

bind ibl_loader ibl_loader_assertions #(.HALF_BIT(HALF_BIT)) u_chk
(
  .clk(clk),
  .rst_b(rst_b),
  .sda_oe(sda_oe),
  .scl_oe(scl_oe),
  .boot_serial_data_pin(boot_serial_data_pin),
  .boot_serial_clock_pin(boot_serial_clock_pin),
  .bit_high_period(bit_high_period),
  .bit_low_period(bit_low_period),
  .entry_point(entry_point),
  .wr_strobe(wr_strobe),
  .load_done(load_done),
  .load_fail(load_fail)
);

// [ibl_eeprom_model.sv]
// Purpose: serial memory partner for the loader bench
// Assumes: pull-ups on both lines
// Notes: 256 bytes, pointer wraps
`timescale 1ns/1ns
module ibl_eeprom_model
(
  input wire scl,
  input wire sda,
  input wire ack_en,
  output reg pull
);
  reg [7:0] mem [0:255];
  reg [7:0] sh;
  reg [7:0] dat;
  reg [15:0] ptr;
  integer bc;
  integer ph;
  integer i;
  // never opens a transfer itself
  initial
  begin
    pull = 1'b0;
    ph = 4;
    bc = 0;
    ptr = 16'h0000;
    for (i = 0; i < 256; i = i + 1)
      mem[i] = 8'h00;
  end
  //////////////////////////////
  always @(negedge sda)
    if (scl)
    begin
      ph = 0;
      bc = 0;
    end
  always @(posedge sda)
    if (scl)
      ph = 4;
  // bits counted on rising clock so start edges are not bits
  always @(posedge scl)
  begin
    if (bc < 8)
      sh = {sh[6:0], sda};
    else if (ph == 3 && sda)
      ph = 4;
    bc = bc + 1;
  end
  // phases: 0 address, 1 and 2 pointer, 3 read, 4 idle
  always @(negedge scl)
  begin
    pull = 1'b0;
    if (bc == 8 && ph < 3)
      pull = ack_en && (ph > 0 || sh[7:1] == 7'h50);
    if (bc == 8 && ph == 0 && !pull)
      ph = 4;
    if (bc == 9)
    begin
      bc = 0;
      if (ph == 1)
        ptr[15:8] = sh;
      if (ph == 2)
        ptr[7:0] = sh;
      if (ph < 3)
        ph = ph == 0 ? (sh[0] ? 3 : 1) : (ph == 1 ? 2 : 4);
      if (ph == 3)
      begin
        dat = mem[ptr[7:0]];
        ptr = ptr + 16'h0001;
      end
    end
    if (ph == 3 && bc < 8)
      pull = ~dat[7 - bc];
  end
endmodule // ibl_eeprom_model

// [ibl_loader_tb_top.sv]
// Purpose: self-checking bench for the boot loader
// Assumes: 40 ns clock, initial bit clock near 520 ns
// Notes: short half-bit count keeps runs brief
`timescale 1ns/1ns
module ibl_loader_tb_top;
  localparam HB = 4;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg start = 1'b0;
  reg ack_en = 1'b1;
  wire pull;
  wire sda_out, sda_oe, scl_out, scl_oe, wr_strobe, load_done, load_fail;
  wire [5:0] boot_serial_data_pin, boot_serial_clock_pin;
  wire [7:0] bus_clock_prescaler;
  wire [15:0] bit_high_period, bit_low_period, wr_data;
  wire [31:0] entry_point, wr_addr;
  wire sda_in = ~(sda_oe | pull);
  wire scl_in = ~scl_oe;
  integer num_errors = 0;
  integer total_checks = 0;
  reg [15:0] img [0:20];
  reg [47:0] got [$];
  reg [39:0] early;
  ibl_loader #(.HALF_BIT(HB)) u_dut
  (
    .clk(clk),
    .rst_b(rst_b),
    .start(start),
    .sda_in(sda_in),
    .scl_in(scl_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .scl_out(scl_out),
    .scl_oe(scl_oe),
    .boot_serial_data_pin(boot_serial_data_pin),
    .boot_serial_clock_pin(boot_serial_clock_pin),
    .bus_clock_prescaler(bus_clock_prescaler),
    .bit_high_period(bit_high_period),
    .bit_low_period(bit_low_period),
    .entry_point(entry_point),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strobe(wr_strobe),
    .load_done(load_done),
    .load_fail(load_fail)
  );
  ibl_eeprom_model u_mem (.scl(scl_in), .sda(sda_in), .ack_en(ack_en), .pull(pull));
  always #20 clk = ~clk;
  always @(posedge clk)
    if (wr_strobe)
      got.push_back({wr_addr, wr_data});
  //////////////////////////////
  task chk(input [47:0] gv, input [47:0] ev);
    begin
      total_checks = total_checks + 1;
      if (gv !== ev)
      begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t got %h exp %h", $time, gv, ev);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // reserved words nonzero so acting on them shows
  task set_img;
    img = '{16'h08aa, 16'h7701, 16'h0003, 16'h0006, 16'h1111, 16'h2222, 16'h3333,
      16'h4444, 16'h5555, 16'h5a12, 16'h3456, 16'h0002, 16'h0001, 16'h2340,
      16'habcd, 16'h1234, 16'h0001, 16'h0000, 16'h0050, 16'hbeef, 16'h0000};
  endtask
  task run;
    integer i;
    begin
      rst_b <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 21; i = i + 1)
      begin
        u_mem.mem[2 * i] = img[i][7:0];
        u_mem.mem[2 * i + 1] = img[i][15:8];
      end
      repeat (3) @(posedge clk);
      got.delete();
      rst_b <= 1'b1;
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (4) @(posedge clk);
      early = {bus_clock_prescaler, bit_high_period, bit_low_period};
      i = 0;
      while (!(load_done || load_fail) && i < 40000)
      begin
        @(posedge clk);
        i = i + 1;
      end
      if (i == 40000)
      begin
        num_errors = num_errors + 1;
        test_done;
      end
      repeat (700) @(posedge clk);
    end
  endtask
  //////////////////////////////
  task test_nack;
    begin
      ack_en <= 1'b0;
      set_img;
      run;
      chk(load_fail, 1'b1);
      chk(load_done, 1'b0);
      chk(got.size(), 48'h0);
      chk({sda_oe, scl_oe}, 2'b00);
      ack_en <= 1'b1;
      $display("test nack_first done");
    end
  endtask
  task test_bad_key;
    begin
      set_img;
      img[0] = 16'haa08;
      run;
      chk(load_fail, 1'b1);
      chk(load_done, 1'b0);
      chk(got.size(), 48'h0);
      $display("test bad_key done");
    end
  endtask
  task test_good_load;
    begin
      set_img;
      run;
      chk(early, {8'h00, 16'h0004, 16'h0004});
      chk({boot_serial_data_pin, boot_serial_clock_pin}, 12'h821);
      chk(load_done, 1'b1);
      chk(load_fail, 1'b0);
      chk(bus_clock_prescaler, 8'h01);
      chk({bit_high_period, bit_low_period}, 32'h0003_0006);
      chk(entry_point, 32'h0012_3456);
      chk(got.size(), 48'h3);
      chk(got[0], {32'h0001_2340, 16'habcd});
      chk(got[1], {32'h0001_2341, 16'h1234});
      chk(got[2], {32'h0000_0050, 16'hbeef});
      chk({sda_out, scl_out, sda_oe, scl_oe}, 4'h0);
      $display("test good_load done");
    end
  endtask
  initial
  begin
    test_nack;
    test_bad_key;
    test_good_load;
    test_done;
  end
endmodule // ibl_loader_tb_top
